// ---- core/ckdst_top.v ----
`timescale 1ns/1ps
// Behaviour
// - All seven clock sources feed every divider input multiplexer.
// - The system clock is the fastest clock and the reference for all others.
// - A 16-bit divider makes the bus clock from the system clock.
// - The processor clock is the bus clock with no further division.
// - Eight programmable 16-bit digital dividers take any of the sources.
// - Four 16-bit analog dividers have skew control on their edges.
// - Each digital and analog divider picks its input through its own eight-way multiplexer.
// - Dividers divide by one (bypass) or by two and up, the latter with roughly half duty cycle.
// - Divider inputs are resynchronised and deglitched on the system clock.
// - Digital outputs go to the fabric and come back as inputs for chaining.
// - Eight extra fabric clocks connect one each to the digital dividers.
// - USB data runs on its own 48 MHz clock, its bus side on bus clock.
// - The USB clock is fabric 48 MHz or a doubled 24 MHz source.
// - The watch crystal drives the sleep timer and a once a second tick.
// - The doubler gives twice its input, 48 MHz from 24 MHz.
module ckdst_top (
	// Clock and reset; clk_i is the fastest clock present.
	input wire clk_i,
	input wire reset_n_i,
	// Seven clock sources, as pins from other domains.
	input wire internal_main_oscillator_i,
	input wire high_speed_crystal_osc_i,
	input wire fabric_clk_i,
	input wire pll_clk_i,
	input wire doubler_clk_i,
	input wire low_speed_osc_i,
	input wire watch_crystal_oscillator_i,
	// Extra fabric clocks, one per digital divider.
	input wire [7:0] fabric_extra_clk_i,
	// Fabric 48 MHz clock for USB.
	input wire fabric_usb48_i,
	// Register port.
	input wire [5:0] addr_i,
	input wire [15:0] wdata_i,
	input wire wr_i,
	input wire rd_i,
	output reg [15:0] rdata_o,
	// Clocks out.
	output reg sys_clk_en_o,
	output reg bus_clk_o,
	output reg cpu_clk_o,
	output reg [7:0] dig_clk_o,
	output reg [3:0] ana_clk_o,
	output reg [1:0] doubler_src_o,
	output reg usb_clk_sel_fab_o,
	output reg usb_clk_o,
	output reg sleep_tick_o,
	output reg irq_o
);
`include "ckdst_regs.vh"
	integer i;
	integer j;
	reg [15:0] raw;
	// Three-stage synchronisers; a change counts once stages 2 and 3 agree.
	reg [15:0] s1_ff;
	reg [15:0] s2_ff;
	reg [15:0] s3_ff;
	reg [15:0] clean_ff;
	wire [6:0] src7;
	reg [15:0] busdiv_ff;
	reg [15:0] buscnt_ff;
	reg [15:0] busdiv_act_ff;
	reg [2:0] usb_ff;
	reg [7:0] dcfg_ff [0:7];
	reg [15:0] ddiv_ff [0:7];
	reg [7:0] acfg_ff [0:3];
	reg [15:0] adiv_ff [0:3];
	reg [`CKDST_ST_W-1:0] status_ff;
	reg [`CKDST_ST_W-1:0] mask_ff;
	reg [14:0] rtc_ff;
	reg [15:0] sec_ff;
	reg [11:0] slp_ff;
	reg wco_prev_ff;
	reg [15:0] nxt_rdata;
	wire wco_rise;
	wire sec_evt;
	wire slp_evt;
	wire [`CKDST_ST_W-1:0] evt;
	wire [7:0] dig_w;
	wire [3:0] ana_w;
	wire bus_rise;

	always @* begin
		raw = {fabric_usb48_i, fabric_extra_clk_i, watch_crystal_oscillator_i,
			low_speed_osc_i, doubler_clk_i, pll_clk_i, fabric_clk_i,
			high_speed_crystal_osc_i, internal_main_oscillator_i};
	end
	// Resynchronise to the system clock; deglitch by agreement.
	always @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			s1_ff <= 16'h0000;
			s2_ff <= 16'h0000;
			s3_ff <= 16'h0000;
			clean_ff <= 16'h0000;
		end else begin
			s1_ff <= raw;
			s2_ff <= s1_ff;
			s3_ff <= s2_ff;
			for (i = 0; i < 16; i = i + 1) begin
				if (s2_ff[i] == s3_ff[i])
					clean_ff[i] <= s3_ff[i];
			end
		end
	end
	assign src7 = clean_ff[6:0];

	// Digital dividers: seven sources plus own fabric clock.
	genvar g;
	generate
		for (g = 0; g < 8; g = g + 1) begin : gdig
			ckdst_div u_div (
				.clk_i(clk_i),
				.reset_n_i(reset_n_i),
				.src_i({clean_ff[7 + g], src7}),
				.sel_i(dcfg_ff[g][`CKDST_SEL_MSB:`CKDST_SEL_LSB]),
				.ratio_i(ddiv_ff[g]),
				.skew_i(4'h0),
				.clk_o(dig_w[g])
			);
		end
		// Analog dividers take the digital output of the same index as eighth input.
		for (g = 0; g < 4; g = g + 1) begin : gana
			ckdst_div u_div (
				.clk_i(clk_i),
				.reset_n_i(reset_n_i),
				.src_i({dig_w[g], src7}),
				.sel_i(acfg_ff[g][`CKDST_SEL_MSB:`CKDST_SEL_LSB]),
				.ratio_i(adiv_ff[g]),
				.skew_i(acfg_ff[g][`CKDST_SKEW_MSB:`CKDST_SKEW_LSB]),
				.clk_o(ana_w[g])
			);
		end
	endgenerate

	// Bus clock divider: period of busdiv+1 system clocks, high for about half.
	assign bus_rise = (buscnt_ff == 16'h0000);
	always @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			buscnt_ff <= 16'h0000;
			busdiv_act_ff <= `CKDST_RST_BUSDIV;
			bus_clk_o <= 1'b0;
			cpu_clk_o <= 1'b0;
			sys_clk_en_o <= 1'b0;
		end else begin
			sys_clk_en_o <= 1'b1;
			if (buscnt_ff >= busdiv_act_ff) begin
				buscnt_ff <= 16'h0000;
				busdiv_act_ff <= busdiv_ff;
			end else begin
				buscnt_ff <= buscnt_ff + 16'h0001;
			end
			bus_clk_o <= (busdiv_act_ff == 16'h0000) ? 1'b1 :
				(buscnt_ff <= {1'b0, busdiv_act_ff[15:1]});
			// CPU clock is the same enable as the bus clock.
			cpu_clk_o <= (busdiv_act_ff == 16'h0000) ? 1'b1 :
				(buscnt_ff <= {1'b0, busdiv_act_ff[15:1]});
		end
	end

	// Watch crystal edges: sleep timer and one second tick.
	assign wco_rise = clean_ff[6] & ~wco_prev_ff;
	assign sec_evt = wco_rise && (rtc_ff == `CKDST_WCO_PER_SEC);
	assign slp_evt = wco_rise && (slp_ff == `CKDST_SLEEP_TC);
	assign evt = {slp_evt, sec_evt};
	always @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			wco_prev_ff <= 1'b0;
			rtc_ff <= 15'h0000;
			slp_ff <= 12'h000;
			sec_ff <= 16'h0000;
			sleep_tick_o <= 1'b0;
		end else begin
			wco_prev_ff <= clean_ff[6];
			sleep_tick_o <= slp_evt;
			if (wco_rise) begin
				rtc_ff <= rtc_ff + 15'h0001;
				slp_ff <= slp_ff + 12'h001;
			end
			if (sec_evt)
				sec_ff <= sec_ff + 16'h0001;
		end
	end

	// Registers, status with set winning over clear, and interrupt.
	always @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			busdiv_ff <= `CKDST_RST_BUSDIV;
			usb_ff <= `CKDST_RST_USB;
			status_ff <= {`CKDST_ST_W{1'b0}};
			mask_ff <= {`CKDST_ST_W{1'b0}};
			for (j = 0; j < 8; j = j + 1) begin
				dcfg_ff[j] <= `CKDST_RST_CFG;
				ddiv_ff[j] <= `CKDST_RST_DIV;
			end
			for (j = 0; j < 4; j = j + 1) begin
				acfg_ff[j] <= `CKDST_RST_CFG;
				adiv_ff[j] <= `CKDST_RST_DIV;
			end
			irq_o <= 1'b0;
		end else begin
			if (wr_i) begin
				if (addr_i == `CKDST_A_BUSDIV)
					busdiv_ff <= wdata_i;
				if (addr_i == `CKDST_A_USBCFG)
					usb_ff <= wdata_i[2:0];
				if (addr_i == `CKDST_A_MASK)
					mask_ff <= wdata_i[`CKDST_ST_W-1:0];
				if (addr_i[5:3] == 3'h2)
					dcfg_ff[addr_i[2:0]] <= wdata_i[7:0];
				if (addr_i[5:3] == 3'h3)
					ddiv_ff[addr_i[2:0]] <= wdata_i;
				if (addr_i[5:2] == 4'h8)
					acfg_ff[addr_i[1:0]] <= wdata_i[7:0];
				if (addr_i[5:2] == 4'h9)
					adiv_ff[addr_i[1:0]] <= wdata_i;
			end
			if (wr_i && addr_i == `CKDST_A_STATUS)
				status_ff <= (status_ff & ~wdata_i[`CKDST_ST_W-1:0]) | evt;
			else
				status_ff <= status_ff | evt;
			irq_o <= |(status_ff & mask_ff);
		end
	end

	always @* begin
		nxt_rdata = 16'h0000;
		case (addr_i)
		`CKDST_A_SYSSEL: nxt_rdata = {9'h000, clean_ff[6:0]};
		`CKDST_A_BUSDIV: nxt_rdata = busdiv_ff;
		`CKDST_A_USBCFG: nxt_rdata = {13'h0000, usb_ff};
		`CKDST_A_STATUS: nxt_rdata = {14'h0000, status_ff};
		`CKDST_A_MASK: nxt_rdata = {14'h0000, mask_ff};
		`CKDST_A_RTCCNT: nxt_rdata = sec_ff;
		default: begin
			if (addr_i[5:3] == 3'h2)
				nxt_rdata = {8'h00, dcfg_ff[addr_i[2:0]]};
			else if (addr_i[5:3] == 3'h3)
				nxt_rdata = ddiv_ff[addr_i[2:0]];
			else if (addr_i[5:2] == 4'h8)
				nxt_rdata = {8'h00, acfg_ff[addr_i[1:0]]};
			else if (addr_i[5:2] == 4'h9)
				nxt_rdata = adiv_ff[addr_i[1:0]];
		end
		endcase
	end

	// Outputs; digital clocks go out to the fabric and may return.
	// USB logic itself runs on usb_clk_o, outside this domain.
	always @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rdata_o <= 16'h0000;
			dig_clk_o <= 8'h00;
			ana_clk_o <= 4'h0;
			doubler_src_o <= 2'h0;
			usb_clk_sel_fab_o <= 1'b0;
			usb_clk_o <= 1'b0;
		end else begin
			rdata_o <= rd_i ? nxt_rdata : 16'h0000;
			dig_clk_o <= dig_w;
			ana_clk_o <= ana_w;
			// Doubler source steers the 24 MHz input to be doubled.
			doubler_src_o <= usb_ff[1:0];
			// USB 48 MHz from fabric or doubler.
			usb_clk_sel_fab_o <= usb_ff[`CKDST_USB_FAB_BIT];
			usb_clk_o <= usb_ff[`CKDST_USB_FAB_BIT] ? clean_ff[15] :
				clean_ff[4];
		end
	end
endmodule

// ---- core/ckdst_regs.vh ----
`ifndef CKDST_REGS_VH
`define CKDST_REGS_VH
// Register indices on the plain register port.
`define CKDST_ADDR_W 6
`define CKDST_A_SYSSEL 6'h00
`define CKDST_A_BUSDIV 6'h01
`define CKDST_A_USBCFG 6'h02
`define CKDST_A_STATUS 6'h03
`define CKDST_A_MASK 6'h04
`define CKDST_A_RTCCNT 6'h05
`define CKDST_A_DIGCFG 6'h10
`define CKDST_A_DIGDIV 6'h18
`define CKDST_A_ANACFG 6'h20
`define CKDST_A_ANADIV 6'h24
// Divider config field positions: source select [2:0], skew [7:4].
`define CKDST_SEL_LSB 0
`define CKDST_SEL_MSB 2
`define CKDST_SKEW_LSB 4
`define CKDST_SKEW_MSB 7
// USB config: [1:0] doubler source, [2] take fabric 48 MHz clock.
`define CKDST_USB_FAB_BIT 2
// Status bits.
`define CKDST_ST_RTC 0
`define CKDST_ST_SLEEP 1
`define CKDST_ST_W 2
// Reset values.
`define CKDST_RST_DIV 16'h0001
`define CKDST_RST_BUSDIV 16'h0000
`define CKDST_RST_CFG 8'h00
`define CKDST_RST_USB 3'h0
// Watch crystal: 32768 edges make one second.
`define CKDST_WCO_PER_SEC 15'h7fff
// Sleep timer signals at this count and wraps on the next watch crystal edge.
`define CKDST_SLEEP_TC 12'hfff
`endif

// ---- core/ckdst_div.v ----
`timescale 1ns/1ps
module ckdst_div (
	// Clock and reset.
	input wire clk_i,
	input wire reset_n_i,
	// All eight candidate sources, already resynchronised to the system clock.
	input wire [7:0] src_i,
	// Configuration.
	input wire [2:0] sel_i,
	input wire [15:0] ratio_i,
	input wire [3:0] skew_i,
	// Divided clock.
	output reg clk_o
);
`include "ckdst_regs.vh"
	reg [2:0] sel_ff;
	reg [15:0] ratio_ff;
	reg [15:0] cnt_ff;
	reg prev_ff;
	reg [15:0] sk_ff;
	reg [15:0] nxt_sk;
	reg [3:0] skew_ff;
	wire cur;
	wire rise;
	wire [15:0] half;
	assign cur = src_i[sel_ff];
	assign rise = cur & ~prev_ff;
	assign half = {1'b0, ratio_ff[15:1]};
	always @* begin
		nxt_sk = {sk_ff[14:0], 1'b0};
	end
	always @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			sel_ff <= 3'h0;
			ratio_ff <= `CKDST_RST_DIV;
			cnt_ff <= 16'h0000;
			prev_ff <= 1'b0;
			sk_ff <= 16'h0000;
			skew_ff <= 4'h0;
			clk_o <= 1'b0;
		end else begin
			prev_ff <= cur;
			if (rise) begin
				if (cnt_ff >= ratio_ff || ratio_ff == 16'h0000) begin
					cnt_ff <= 16'h0000;
					// Changes land only at a period boundary.
					sel_ff <= sel_i;
					ratio_ff <= ratio_i;
					// A tap change mid-pulse would leave a runt.
					skew_ff <= skew_i;
				end else begin
					cnt_ff <= cnt_ff + 16'h0001;
				end
			end
			// Ratio holds N-1; zero means bypass, gated by the source.
			if (ratio_ff == 16'h0000) begin
				sk_ff <= {nxt_sk[15:1], cur};
			end else begin
				// About half high, half low for N of two and up.
				sk_ff <= {nxt_sk[15:1], (cnt_ff <= half) ? 1'b1 : 1'b0};
			end
			// Skew taps delay the edge away from digital switching.
			clk_o <= sk_ff[skew_ff];
		end
	end
endmodule

// ---- bench/ckdst_props.sv ----
`timescale 1ns/1ps
module ckdst_props (
	// Clock and reset.
	input wire clk_i,
	input wire reset_n_i,
	// Inputs watched.
	input wire fabric_usb48_i,
	input wire [5:0] addr_i,
	input wire [15:0] wdata_i,
	input wire wr_i,
	input wire rd_i,
	// Outputs watched.
	input wire [15:0] rdata_o,
	input wire sys_clk_en_o,
	input wire bus_clk_o,
	input wire cpu_clk_o,
	input wire [7:0] dig_clk_o,
	input wire [3:0] ana_clk_o,
	input wire [1:0] doubler_src_o,
	input wire usb_clk_sel_fab_o,
	input wire usb_clk_o,
	input wire sleep_tick_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!reset_n_i);
	property p_cpu_bus;
		cpu_clk_o == bus_clk_o;
	endproperty
	a_cpu_bus: assert property (p_cpu_bus)
		else $error("cpu clock differs from bus clock");
	property p_sys_en;
		$past(reset_n_i) |-> sys_clk_en_o;
	endproperty
	a_sys_en: assert property (p_sys_en)
		else $error("system clock enable low");
	property p_tick;
		sleep_tick_o |=> !sleep_tick_o [*8];
	endproperty
	a_tick: assert property (p_tick)
		else $error("sleep tick too close");
	property p_usb_fab;
		usb_clk_sel_fab_o && $rose(fabric_usb48_i) |-> ##[1:6] usb_clk_o;
	endproperty
	a_usb_fab: assert property (p_usb_fab)
		else $error("usb clock does not follow fabric clock");
	property p_usb_cfg;
		wr_i && addr_i == 6'h02 |-> ##2 {13'h0000, usb_clk_sel_fab_o,
			doubler_src_o} == ($past(wdata_i, 2) & 16'h0007);
	endproperty
	a_usb_cfg: assert property (p_usb_cfg)
		else $error("usb select does not match write");
	property p_dig_hi;
		$rose(dig_clk_o[0]) |-> dig_clk_o[0] [*3];
	endproperty
	a_dig_hi: assert property (p_dig_hi)
		else $error("runt high pulse on digital clock");
	property p_ana_lo;
		$fell(ana_clk_o[0]) |-> !ana_clk_o[0] [*3];
	endproperty
	a_ana_lo: assert property (p_ana_lo)
		else $error("runt low pulse on analog clock");
	property p_rd_idle;
		!$past(rd_i) |-> rdata_o == 16'h0000;
	endproperty
	a_rd_idle: assert property (p_rd_idle)
		else $error("read data outside read cycle");
endmodule
bind ckdst_top ckdst_props u_props (.clk_i, .reset_n_i, .fabric_usb48_i,
	.addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .sys_clk_en_o, .bus_clk_o,
	.cpu_clk_o, .dig_clk_o, .ana_clk_o, .doubler_src_o, .usb_clk_sel_fab_o,
	.usb_clk_o, .sleep_tick_o);

// ---- bench/testbench.sv ----
`timescale 1ns/1ps
module testbench;
	logic clk_i = 1'b0;
	logic reset_n_i = 1'b0;
	logic [5:0] addr_i = 6'h00;
	logic [15:0] wdata_i = 16'h0000;
	logic wr_i = 1'b0;
	logic rd_i = 1'b0;
	logic [15:0] cnt = 16'h0000;
	logic [1:0] wdv = 2'h0;
	logic wco = 1'b0;
	wire [15:0] rdata_o;
	wire sys_clk_en_o, bus_clk_o, cpu_clk_o, usb_clk_o, usb_clk_sel_fab_o;
	wire sleep_tick_o, irq_o;
	wire [7:0] dig_clk_o;
	wire [3:0] ana_clk_o;
	wire [1:0] doubler_src_o;
	wire [12:0] outs = {bus_clk_o, ana_clk_o, dig_clk_o};
	int err_total = 0;
	int tests_run = 0;
	ckdst_top DUT (.clk_i, .reset_n_i, .internal_main_oscillator_i(cnt[2]),
		.high_speed_crystal_osc_i(cnt[3]), .fabric_clk_i(cnt[4]),
		.pll_clk_i(cnt[5]), .doubler_clk_i(cnt[6]), .low_speed_osc_i(cnt[7]),
		.watch_crystal_oscillator_i(wco), .fabric_extra_clk_i({8{cnt[3]}}),
		.fabric_usb48_i(cnt[3]), .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
		.sys_clk_en_o, .bus_clk_o, .cpu_clk_o, .dig_clk_o, .ana_clk_o,
		.doubler_src_o, .usb_clk_sel_fab_o, .usb_clk_o, .sleep_tick_o, .irq_o);
	initial begin
		forever #2 clk_i = ~clk_i;
	end
	// Sources run no faster than a sixth of the system clock.
	always @(posedge clk_i) begin
		cnt <= cnt + 16'h0001;
		wdv <= (wdv == 2'h2) ? 2'h0 : wdv + 2'h1;
		if (wdv == 2'h2) wco <= ~wco;
	end
	task conclude;
		$display("checks %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			err_total++;
			$display("unexpected %s expected %0h seen %0h", n, e, g);
		end
	endtask
	task wr(input logic [5:0] a, input logic [15:0] d);
		@(posedge clk_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge clk_i);
		wr_i <= 1'b0;
		#1;
	endtask
	task rd(input logic [5:0] a, output logic [15:0] d);
		@(posedge clk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge clk_i);
		rd_i <= 1'b0;
		#1 d = rdata_o;
	endtask
	task rise(input int b, inout int n);
		while (outs[b] !== 1'b0 && n < 9000) begin
			@(posedge clk_i) #1 n++;
		end
		while (outs[b] !== 1'b1 && n < 9000) begin
			@(posedge clk_i) #1 n++;
		end
	endtask
	// The first rises are skipped so a new setting has reached a wrap.
	task per(input int b, output int p);
		int n;
		n = 0;
		repeat (3) rise(b, n);
		n = 0;
		rise(b, n);
		p = n;
	endtask
	task t_reset;
		logic [15:0] d;
		rd(6'h18, d); chk("ratio reset", 1, d);
		rd(6'h10, d); chk("select reset", 0, d);
		rd(6'h01, d); chk("bus ratio reset", 0, d);
		rd(6'h3f, d); chk("unmapped read", 0, d);
	endtask
	task t_dig;
		int srcp[8] = '{8, 16, 32, 64, 128, 256, 6, 16};
		int p;
		wr(6'h18, 16'h0002);
		for (int k = 0; k < 8; k++) begin
			wr(6'h10, 16'(k));
			per(0, p); chk("digital period", 3 * srcp[k], p);
		end
		wr(6'h19, 16'h0000);
		per(1, p); chk("bypass period", 8, p);
	endtask
	task t_chain;
		int p;
		int n;
		wr(6'h20, 16'h0037);
		wr(6'h24, 16'h0001);
		per(8, p); chk("chained period", 96, p);
		// Analog 1 and 2 run in step from reset; only 2 gets a skew.
		wr(6'h22, 16'h0050);
		repeat (40) @(posedge clk_i);
		n = 0;
		rise(9, n);
		n = 0;
		rise(10, n); chk("skew delay", 5, n);
		wr(6'h01, 16'h0003);
		per(12, p); chk("bus period", 4, p);
	endtask
	task t_usb;
		for (int k = 0; k < 8; k++) begin
			wr(6'h02, 16'(k));
			@(posedge clk_i);
			#1 chk("usb select", k, {usb_clk_sel_fab_o, doubler_src_o});
		end
		repeat (40) @(posedge clk_i);
	endtask
	task t_irq;
		logic [15:0] d;
		int n;
		wr(6'h04, 16'h0002);
		n = 0;
		while (sleep_tick_o !== 1'b1 && n < 40000) begin
			@(posedge clk_i) #1 n++;
		end
		repeat (3) @(posedge clk_i);
		#1 chk("irq raised", 1, irq_o);
		rd(6'h03, d); chk("wrap status", 2, d & 16'h0002);
		rd(6'h05, d); chk("seconds", 0, d);
		wr(6'h04, 16'h0000);
		repeat (2) @(posedge clk_i);
		#1 chk("irq masked", 0, irq_o);
		wr(6'h04, 16'h0002);
		repeat (2) @(posedge clk_i);
		#1 chk("irq unmasked", 1, irq_o);
		wr(6'h03, 16'h0002);
		repeat (2) @(posedge clk_i);
		#1 chk("irq cleared", 0, irq_o);
		rd(6'h03, d); chk("status cleared", 0, d & 16'h0002);
	endtask
	initial begin
		repeat (12) @(posedge clk_i);
		reset_n_i <= 1'b1;
		t_reset;
		t_dig;
		t_chain;
		t_usb;
		t_irq;
		conclude;
	end
	initial begin
		repeat (90000) @(posedge clk_i);
		err_total++;
		conclude;
	end
endmodule
